// file: include/mgmt_port_pkg.sv
// Constants and types shared by the management serial port design
package mgmt_port_pkg;

  // ****************************************************************
  // Timing
  // ****************************************************************
  localparam int MCLK_PERIOD_PS = 5000;
  // Management clock half period, 10 Mb/s serial rate
  localparam int MGMT_HALF_NS   = 50;
  // Longest time, so rounded down; never below one cycle
  localparam int MGMT_HALF_CYC_RAW = (MGMT_HALF_NS * 1000) / MCLK_PERIOD_PS;
  localparam int MGMT_HALF_CYC  = (MGMT_HALF_CYC_RAW < 1) ? 1
                                                          : MGMT_HALF_CYC_RAW;

  // ****************************************************************
  // Defaults for sizes not fixed by the device
  // ****************************************************************
  localparam int STATUS_BITS_DEF   = 16;
  localparam int COMPRESS_BITS_DEF = 512;
  localparam int BIT_CNT_W         = 16;

  // ****************************************************************
  // Idle levels
  // ****************************************************************
  localparam logic CLK_IDLE_LVL = 1'h1;
  localparam logic DAT_IDLE_LVL = 1'h0;

  // ****************************************************************
  // Port sequencer states
  // ****************************************************************
  typedef enum logic [2:0] {
    ST_IDLE   = 3'h1,
    ST_DATA   = 3'h2,
    ST_STATUS = 3'h4
  } seq_state_type;

endpackage

// file: verilog/hub_mgmt_serial_port.sv
// Management serial output port: packet plus status stream
`timescale 1ns/1ps

// Overview of operation
// - The management clock toggles only while a frame is being sent.
// - While the lines are driven, serial data changes only together with a falling clock edge.
// - Serial data carries the NRZ packet then status, idle otherwise.
// - Carrier sense is driven high around the stream, else released.
// - The bus drive enable is high whenever the three lines are driven.
// - A low compress request while the packet is sent (ST_DATA) truncates the packet.
// - Received Manchester data is mirrored on a test monitor output.
// - A status field is appended after the end of the packet.
// - All timing comes from the one reference clock input.
// - A low reset and mode load input holds the port reset and idle.
module hub_mgmt_serial_port #(
  parameter int STATUS_BITS   = mgmt_port_pkg::STATUS_BITS_DEF,
  parameter int COMPRESS_BITS = mgmt_port_pkg::COMPRESS_BITS_DEF,
  parameter int HALF_CYC      = mgmt_port_pkg::MGMT_HALF_CYC
) (
  input  wire logic                   MCLK_I,
  input  wire logic                   SYS_RST_I,
  input  wire logic                   RESET_AND_MODE_LOAD_N_I,
  input  wire logic                   RX_ACTIVE_I,
  input  wire logic                   RX_NRZ_VALID_I,
  input  wire logic                   RX_NRZ_DATA_I,
  input  wire logic                   RX_MANCHESTER_I,
  input  wire logic [STATUS_BITS-1:0] STATUS_I,
  input  wire logic                   PACKET_COMPRESS_REQ_N_I,
  input  wire logic                   MGMT_CARRIER_SENSE_I,
  output logic                        MGMT_CARRIER_SENSE_O,
  output logic                        MGMT_CARRIER_SENSE_OE_N_O,
  output logic                        MGMT_RX_CLOCK_O,
  output logic                        MGMT_RX_CLOCK_OE_N_O,
  output logic                        MGMT_RX_SERIAL_DATA_O,
  output logic                        MGMT_RX_SERIAL_DATA_OE_N_O,
  output logic                        MGMT_BUS_DRIVE_ENABLE_O,
  output logic                        MANCHESTER_RX_MONITOR_O
);

  localparam int HCW = (HALF_CYC > 1) ? $clog2(HALF_CYC) : 1;
  localparam int SCW = $clog2(STATUS_BITS + 1);
  localparam logic [HCW-1:0] HALF_LAST = HCW'(HALF_CYC - 1);
  localparam logic [SCW-1:0] STS_LAST  = SCW'(STATUS_BITS);
  localparam logic [mgmt_port_pkg::BIT_CNT_W-1:0] CMP_LIMIT =
    mgmt_port_pkg::BIT_CNT_W'(COMPRESS_BITS);

  mgmt_port_pkg::seq_state_type state_reg;
  logic                   rst;
  logic [HCW-1:0]         half_cnt_reg;
  logic                   clk_reg;
  logic                   sdata_reg;
  logic                   pend_vld_reg;
  logic                   pend_bit_reg;
  logic [STATUS_BITS-1:0] sts_shift_reg;
  logic [SCW-1:0]         sts_cnt_reg;
  logic [mgmt_port_pkg::BIT_CNT_W-1:0] data_cnt_reg;
  logic                   compress_reg;
  logic                   mon_reg;
  logic                   active;
  logic                   half_done;
  logic                   fall_ok;
  logic                   start;
  logic                   drop;
  logic                   to_status;

  // ****************************************************************
  // Reset and sequencing terms
  // ****************************************************************
  // Either reset source idles the port, with no clock needed beyond MCLK
  assign rst       = SYS_RST_I || !RESET_AND_MODE_LOAD_N_I;
  assign active    = (state_reg != mgmt_port_pkg::ST_IDLE);
  assign half_done = (half_cnt_reg == HALF_LAST);
  // A falling edge is only due after a full high half period
  assign fall_ok   = active && half_done && clk_reg;
  assign start     = (state_reg == mgmt_port_pkg::ST_IDLE) && pend_vld_reg;
  assign to_status = (state_reg == mgmt_port_pkg::ST_DATA) && fall_ok &&
                     !pend_vld_reg && !RX_ACTIVE_I;
  assign drop      = compress_reg && (data_cnt_reg >= CMP_LIMIT);

  // ****************************************************************
  // Sequencer
  // ****************************************************************
  always_ff @(posedge MCLK_I) begin
    if (rst) begin
      state_reg <= mgmt_port_pkg::ST_IDLE;
    end else begin
      case (state_reg)
        mgmt_port_pkg::ST_IDLE: begin
          if (start) begin
            state_reg <= mgmt_port_pkg::ST_DATA;
          end
        end
        mgmt_port_pkg::ST_DATA: begin
          if (to_status) begin
            state_reg <= mgmt_port_pkg::ST_STATUS;
          end
        end
        mgmt_port_pkg::ST_STATUS: begin
          if (fall_ok && sts_cnt_reg == STS_LAST) begin
            state_reg <= mgmt_port_pkg::ST_IDLE;
          end
        end
        default: begin
          state_reg <= mgmt_port_pkg::ST_IDLE;
        end
      endcase
    end
  end

  // ****************************************************************
  // Serial clock divider
  // ****************************************************************
  // With no bit waiting, the clock is parked high rather than padded
  always_ff @(posedge MCLK_I) begin
    if (rst || !active || start) begin
      half_cnt_reg <= '0;
    end else if (!half_done) begin
      half_cnt_reg <= half_cnt_reg + HCW'(1);
    end else if (!clk_reg || fall_ok &&
                 (state_reg != mgmt_port_pkg::ST_DATA ||
                  pend_vld_reg || !RX_ACTIVE_I)) begin
      half_cnt_reg <= '0;
    end
  end

  always_ff @(posedge MCLK_I) begin
    if (rst) begin
      clk_reg <= mgmt_port_pkg::CLK_IDLE_LVL;
    end else if (start) begin
      clk_reg <= 1'h0;
    end else if (active && half_done && !clk_reg) begin
      clk_reg <= 1'h1;
    end else if (fall_ok && state_reg == mgmt_port_pkg::ST_DATA &&
                 (pend_vld_reg || !RX_ACTIVE_I)) begin
      clk_reg <= 1'h0;
    end else if (fall_ok && state_reg == mgmt_port_pkg::ST_STATUS &&
                 sts_cnt_reg != STS_LAST) begin
      clk_reg <= 1'h0;
    end
  end

  // ****************************************************************
  // Data path: one bit of hold, then packet bits, then status
  // ****************************************************************
  always_ff @(posedge MCLK_I) begin
    if (rst) begin
      pend_vld_reg <= 1'h0;
      pend_bit_reg <= 1'h0;
    end else if (RX_ACTIVE_I && RX_NRZ_VALID_I && !drop) begin
      // New bit wins over consumption of the old one
      pend_vld_reg <= 1'h1;
      pend_bit_reg <= RX_NRZ_DATA_I;
    end else if (start || fall_ok &&
                 state_reg == mgmt_port_pkg::ST_DATA) begin
      pend_vld_reg <= 1'h0;
    end
  end

  always_ff @(posedge MCLK_I) begin
    if (rst) begin
      sdata_reg <= mgmt_port_pkg::DAT_IDLE_LVL;
    end else if (start || fall_ok && pend_vld_reg &&
                 state_reg == mgmt_port_pkg::ST_DATA) begin
      sdata_reg <= pend_bit_reg;
    end else if (to_status) begin
      sdata_reg <= STATUS_I[0];
    end else if (fall_ok && state_reg == mgmt_port_pkg::ST_STATUS &&
                 sts_cnt_reg != STS_LAST) begin
      sdata_reg <= sts_shift_reg[0];
    end else if (!active) begin
      sdata_reg <= mgmt_port_pkg::DAT_IDLE_LVL;
    end
  end

  // Status is captured once, as the packet closes, and sent LSB first
  always_ff @(posedge MCLK_I) begin
    if (rst) begin
      sts_shift_reg <= '0;
      sts_cnt_reg   <= '0;
    end else if (to_status) begin
      sts_shift_reg <= STATUS_I >> 1;
      sts_cnt_reg   <= SCW'(1);
    end else if (fall_ok && state_reg == mgmt_port_pkg::ST_STATUS &&
                 sts_cnt_reg != STS_LAST) begin
      sts_shift_reg <= sts_shift_reg >> 1;
      sts_cnt_reg   <= sts_cnt_reg + SCW'(1);
    end
  end

  // ****************************************************************
  // Packet compression
  // ****************************************************************
  // Compression only truncates the data; the status field still follows
  // Count clears once receive has ended outside ST_DATA, so a frame that opens right after
  // the previous status field does not inherit its bit count
  always_ff @(posedge MCLK_I) begin
    if (rst || state_reg != mgmt_port_pkg::ST_DATA && !RX_ACTIVE_I) begin
      data_cnt_reg <= '0;
    end else if (RX_ACTIVE_I && RX_NRZ_VALID_I && !drop) begin
      data_cnt_reg <= data_cnt_reg + mgmt_port_pkg::BIT_CNT_W'(1);
    end
  end

  always_ff @(posedge MCLK_I) begin
    if (rst) begin
      compress_reg <= 1'h0;
    end else if (state_reg == mgmt_port_pkg::ST_DATA &&
                 !PACKET_COMPRESS_REQ_N_I) begin
      compress_reg <= 1'h1;
    end else if (state_reg == mgmt_port_pkg::ST_IDLE) begin
      compress_reg <= 1'h0;
    end
  end

  // ****************************************************************
  // Test monitor and pin drive
  // ****************************************************************
  always_ff @(posedge MCLK_I) begin
    if (rst) begin
      mon_reg <= 1'h0;
    end else begin
      mon_reg <= RX_ACTIVE_I && RX_MANCHESTER_I;
    end
  end

  assign MANCHESTER_RX_MONITOR_O    = mon_reg;
  assign MGMT_RX_CLOCK_O            = clk_reg;
  assign MGMT_RX_SERIAL_DATA_O      = sdata_reg;
  assign MGMT_CARRIER_SENSE_O       = active;
  // Lines released while idle so other hubs may share the bus
  assign MGMT_CARRIER_SENSE_OE_N_O  = !active;
  assign MGMT_RX_CLOCK_OE_N_O       = !active;
  assign MGMT_RX_SERIAL_DATA_OE_N_O = !active;
  assign MGMT_BUS_DRIVE_ENABLE_O    = active;

  // ****************************************************************
  // Checks
  // ****************************************************************
  default clocking cb @(posedge MCLK_I); endclocking
  default disable iff (rst);

  sequence s_packet_end;
    to_status;
  endsequence
  sequence s_status_first;
    state_reg == mgmt_port_pkg::ST_STATUS && sts_cnt_reg == SCW'(1);
  endsequence

  a_idle_released: assert property (
    !active |-> MGMT_RX_CLOCK_OE_N_O && MGMT_RX_SERIAL_DATA_OE_N_O &&
                !MGMT_BUS_DRIVE_ENABLE_O)
    else $error("idle port still drives the bus");
  a_data_on_fall: assert property (
    ($changed(sdata_reg) && active && $past(active)) |-> $fell(clk_reg))
    else $error("serial data changed off a falling clock edge");
  a_clock_half: assert property (
    ($rose(clk_reg) && active) |-> $past(half_cnt_reg) == HALF_LAST)
    else $error("clock low half has wrong length");
  a_frame_start: assert property (
    start |=> active && !MGMT_CARRIER_SENSE_OE_N_O && !clk_reg &&
              MGMT_CARRIER_SENSE_O)
    else $error("frame start did not assert carrier sense");
  a_enable_tied: assert property (
    MGMT_BUS_DRIVE_ENABLE_O == !MGMT_RX_CLOCK_OE_N_O)
    else $error("drive enable does not follow line drive");
  a_compress_set: assert property (
    (state_reg == mgmt_port_pkg::ST_DATA && !PACKET_COMPRESS_REQ_N_I)
      |=> compress_reg)
    else $error("compress request not taken");
  a_status_append: assert property (
    s_packet_end |=> s_status_first ##0 sdata_reg == $past(STATUS_I[0]))
    else $error("status field did not follow packet");
  a_monitor_copy: assert property (
    RX_ACTIVE_I |=> mon_reg == $past(RX_MANCHESTER_I))
    else $error("monitor output not tracking received data");
  a_reset_hold: assert property (
    @(posedge MCLK_I) disable iff (1'b0)
    rst |=> !active && clk_reg)
    else $error("port active during reset");

endmodule

// file: tb/mgmt_ctrl_model.sv
// Management controller model: collects the serial stream
`timescale 1ns/1ps
module mgmt_ctrl_model (
  input wire logic mgmt_rx_clock_i,
  input wire logic mgmt_carrier_sense_i,
  input wire logic mgmt_rx_serial_data_i
);
  // Bits taken so far; send_frame empties it before each frame it sends
  logic got_q[$];

  // Sample on the rising edge, opposite to the launch edge
  always @(posedge mgmt_rx_clock_i) begin
    if (mgmt_carrier_sense_i === 1'b1) begin
      got_q.push_back(mgmt_rx_serial_data_i);
    end
  end
endmodule

// file: tb/tb_hub_mgmt_serial_port.sv
// Testbench for the management serial output port
`timescale 1ns/1ps
module tb_hub_mgmt_serial_port;
  localparam int SB = 8;
  localparam int CB = 8;
  localparam int HC = 2;
  logic          mclk = 1'b0;
  logic          sys_rst = 1'b1;
  logic          mode_load_n = 1'b1;
  logic          rx_active = 1'b0;
  logic          nrz_valid = 1'b0;
  logic          nrz_data = 1'b0;
  logic          manch = 1'b0;
  logic [SB-1:0] status = 8'h00;
  logic          comp_n = 1'b1;
  logic          cs_o, cs_oe_n, clk_o, clk_oe_n, dat_o, dat_oe_n, en_o, mon_o;
  logic          clk_bus, cs_bus, dat_bus, man_exp, c_q, d_q, dq_drv;
  logic [1:0]    rst_sh = 2'h3;
  int            mismatches = 0;
  int            n_tests = 0;
  int            cyc = 0;

  // Released lines: clock and data pulled up, carrier sense pulled down
  assign clk_bus = clk_oe_n ? 1'b1 : clk_o;
  assign cs_bus  = cs_oe_n ? 1'b0 : cs_o;
  assign dat_bus = dat_oe_n ? 1'b1 : dat_o;

  hub_mgmt_serial_port #(
    .STATUS_BITS   (SB),
    .COMPRESS_BITS (CB),
    .HALF_CYC      (HC)
  ) hub_mgmt_serial_port_inst (
    .MCLK_I                     (mclk),
    .SYS_RST_I                  (sys_rst),
    .RESET_AND_MODE_LOAD_N_I    (mode_load_n),
    .RX_ACTIVE_I                (rx_active),
    .RX_NRZ_VALID_I             (nrz_valid),
    .RX_NRZ_DATA_I              (nrz_data),
    .RX_MANCHESTER_I            (manch),
    .STATUS_I                   (status),
    .PACKET_COMPRESS_REQ_N_I    (comp_n),
    .MGMT_CARRIER_SENSE_I       (cs_bus),
    .MGMT_CARRIER_SENSE_O       (cs_o),
    .MGMT_CARRIER_SENSE_OE_N_O  (cs_oe_n),
    .MGMT_RX_CLOCK_O            (clk_o),
    .MGMT_RX_CLOCK_OE_N_O       (clk_oe_n),
    .MGMT_RX_SERIAL_DATA_O      (dat_o),
    .MGMT_RX_SERIAL_DATA_OE_N_O (dat_oe_n),
    .MGMT_BUS_DRIVE_ENABLE_O    (en_o),
    .MANCHESTER_RX_MONITOR_O    (mon_o)
  );

  mgmt_ctrl_model mgmt_ctrl_model_inst (
    .mgmt_rx_clock_i       (clk_bus),
    .mgmt_carrier_sense_i  (cs_bus),
    .mgmt_rx_serial_data_i (dat_bus)
  );

  always #2.5 mclk = ~mclk;

  always @(negedge mclk) begin
    manch <= ~manch;
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      mismatches++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic test_done();
    $display("mismatches=%0d n_tests=%0d", mismatches, n_tests);
    if (mismatches == 0 && n_tests > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  // ****************************************************************
  // Cycle by cycle pin checks
  // ****************************************************************
  always @(posedge mclk) begin
    rst_sh <= {rst_sh[0], sys_rst | ~mode_load_n};
    man_exp <= manch & rx_active;
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      mismatches++;
      test_done();
    end
  end

  // Outputs are judged at the falling edge, once settled
  always @(negedge mclk) begin
    if (rst_sh == 2'h0) begin
      check(mon_o, man_exp);
      check({en_o, en_o, en_o}, {!clk_oe_n, !dat_oe_n, !cs_oe_n});
      check(cs_o, !cs_oe_n);
      if (clk_o !== c_q) check(cs_o, 1'b1);
      if (dat_o !== d_q && !dat_oe_n && dq_drv) begin
        check({c_q, clk_o}, 2'h2);
      end
    end
    c_q <= clk_o;
    d_q <= dat_o;
    dq_drv <= ~dat_oe_n;
  end

  // ****************************************************************
  // Scenarios
  // ****************************************************************
  task automatic feed_bit(input logic b);
    @(negedge mclk);
    nrz_valid = 1'b1;
    nrz_data = b;
    @(negedge mclk);
    nrz_valid = 1'b0;
    repeat (2 * HC - 1) @(negedge mclk);
  endtask

  task automatic wait_idle();
    int k;
    for (k = 0; k < 400 && cs_o !== 1'b0; k++) @(negedge mclk);
    check(k < 400, 1'b1);
    check({clk_oe_n, dat_oe_n, cs_oe_n, en_o, clk_o}, 5'h1D);
  endtask

  // Mode 0 no compress, 1 compress tied low, 2 one bit time low
  task automatic send_frame(input logic [15:0] pat, input int nb,
                            input logic [7:0] st, input int mode);
    int kept;
    int i;
    kept = (mode != 0 && nb > CB) ? CB : nb;
    mgmt_ctrl_model_inst.got_q.delete();
    comp_n = (mode == 1) ? 1'b0 : 1'b1;
    status = st;
    rx_active = 1'b1;
    for (i = 0; i < nb; i++) begin
      if (mode == 2) comp_n = (i != 3);
      feed_bit(pat[i]);
    end
    rx_active = 1'b0;
    wait_idle();
    comp_n = 1'b1;
    check(mgmt_ctrl_model_inst.got_q.size(), kept + SB);
    if (mgmt_ctrl_model_inst.got_q.size() == kept + SB) begin
      for (i = 0; i < kept; i++) begin
        check(mgmt_ctrl_model_inst.got_q[i], pat[i]);
      end
      for (i = 0; i < SB; i++) begin
        check(mgmt_ctrl_model_inst.got_q[kept + i], st[i]);
      end
    end
  endtask

  // Device reset in mid frame, receive still active
  task automatic reset_mid();
    rx_active = 1'b1;
    feed_bit(1'b1);
    feed_bit(1'b0);
    mode_load_n = 1'b0;
    @(negedge mclk);
    @(negedge mclk);
    check({clk_oe_n, dat_oe_n, cs_oe_n, en_o, clk_o, mon_o}, 6'h3A);
    mode_load_n = 1'b1;
    rx_active = 1'b0;
    wait_idle();
  endtask

  initial begin
    repeat (6) @(negedge mclk);
    sys_rst = 1'b0;
    repeat (2) @(negedge mclk);
    wait_idle();
    send_frame(16'hA5C3, 12, 8'h5A, 0);
    send_frame(16'h3C96, 12, 8'hC1, 1);
    send_frame(16'h0F69, 12, 8'h81, 2);
    send_frame(16'h0001, 1, 8'h7E, 0);
    send_frame(16'hFFFF, 16, 8'h00, 0);
    reset_mid();
    test_done();
  end
endmodule
